// >>> logic/rectifier_alarm_led_status.sv
// front panel LED and open-drain alarm logic of the rectifier
`timescale 1ns/10ps
`include "led_map.svh"
module rectifier_alarm_led_status #(
    parameter logic [31:0] OTW_HOLD_CYCLES =
        32'(`OTW_HOLD_MS * `CLK_KHZ),
    parameter logic [31:0] BLINK_HALF_CYCLES =
        32'(`BLINK_HALF_MS * `CLK_KHZ),
    parameter logic [31:0] PG_PULSE_CYCLES =
        32'(`PG_PULSE_MS * `CLK_KHZ)
) (
    input wire logic clk,
    input wire logic reset,
    input wire led_pkg::mode_t mode,
    input wire led_pkg::cond_t cond,
    output logic input_ok_led,
    output logic output_ok_led,
    output logic service_led,
    output logic fault_led,
    input wire logic fault_n_in,
    output logic fault_n_out,
    output logic fault_n_oe,
    input wire logic over_temp_warn_n_in,
    output logic over_temp_warn_n_out,
    output logic over_temp_warn_n_oe,
    input wire logic output_good_n_in,
    output logic output_good_n_out,
    output logic output_good_n_oe,
    output logic thermal_shutdown,
    output led_pkg::therm_t therm_state
);

    led_pkg::therm_t therm_r;
    led_pkg::therm_t therm_nxt;
    logic [31:0] warn_cnt_r;
    logic warn_done;
    logic blink;
    logic pg_pulse;
    logic standby;
    logic i2c_like;
    led_pkg::ind_t ind_nxt;
    led_pkg::ind_t ind_r;

    // slow flash for the LEDs
    toggle_gen #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .clk(clk),
        .reset(reset),
        .wave(blink)
    );

    // 2 ms period square wave used on output-good while overloaded
    toggle_gen #(
        .HALF_CYCLES(PG_PULSE_CYCLES)
    ) u_pg_pulse (
        .clk(clk),
        .reset(reset),
        .wave(pg_pulse)
    );

    // analog and i2c share the same pin set; only rs485 differs
    assign i2c_like = (mode != led_pkg::MODE_RS485);

    // standby source depends on the protocol strap
    always_comb begin
        if (i2c_like) begin
            standby = cond.onoff_off | cond.i2c_off_cmd; // RULE_07
        end else begin
            standby = cond.interlock_off | cond.rs485_off_cmd; // RULE_07
        end
    end

    // the warning window lasts the full hold count before the trip
    assign warn_done = (warn_cnt_r >= OTW_HOLD_CYCLES - 32'h0000_0001);

    // thermal sequence: warn for the hold time, trip, wait for recovery
    always_comb begin
        therm_nxt = therm_r;
        case (therm_r)
            led_pkg::THERM_OK: begin
                if (cond.over_temp) begin
                    therm_nxt = led_pkg::THERM_WARN; // RULE_14
                end
            end
            led_pkg::THERM_WARN: begin
                if (!cond.over_temp) begin
                    therm_nxt = led_pkg::THERM_OK;
                end else if (warn_done) begin
                    therm_nxt = led_pkg::THERM_SHUT; // RULE_14
                end
            end
            led_pkg::THERM_SHUT: begin
                // restart only once the heat sink is back in range
                if (cond.temp_recovered && !cond.over_temp) begin
                    therm_nxt = led_pkg::THERM_OK; // RULE_14
                end
            end
            default: begin
                therm_nxt = led_pkg::THERM_OK;
            end
        endcase
    end

    // thermal state register
    always_ff @(posedge clk) begin
        if (reset) begin
            therm_r <= led_pkg::THERM_OK;
        end else begin
            therm_r <= therm_nxt;
        end
    end

    // warning timer runs only inside the warning window
    always_ff @(posedge clk) begin
        if (reset) begin
            warn_cnt_r <= 32'h0000_0000;
        end else if (therm_r == led_pkg::THERM_WARN) begin
            if (!warn_done) begin
                warn_cnt_r <= warn_cnt_r + 32'h0000_0001; // RULE_14
            end
        end else begin
            warn_cnt_r <= 32'h0000_0000;
        end
    end

    // resolve one picture from the conditions, most severe first.
    // a single priority chain keeps two conditions from fighting over
    // one LED; the cost is that lesser conditions are hidden meanwhile.
    always_comb begin
        // normal operation as the fallback picture
        ind_nxt.input_ok_led = 1'b1; // RULE_11
        ind_nxt.output_ok_led = 1'b1; // RULE_11
        ind_nxt.service_led = 1'b0; // RULE_11
        ind_nxt.fault_led = 1'b0; // RULE_11
        ind_nxt.fault_act = 1'b0; // RULE_11
        ind_nxt.over_temp_warn_act = 1'b0; // RULE_11
        ind_nxt.output_good_act = 1'b0; // RULE_11
        if (!cond.input_present) begin
            // only meaningful while a neighbour supplies back bias
            ind_nxt.input_ok_led = 1'b0; // RULE_10
            ind_nxt.output_ok_led = 1'b0; // RULE_10
            ind_nxt.output_good_act = 1'b1; // RULE_10
        end else if (!cond.input_in_limits) begin
            ind_nxt.input_ok_led = blink; // RULE_01 RULE_04
            ind_nxt.output_ok_led = 1'b0; // RULE_04
            ind_nxt.output_good_act = 1'b1; // RULE_04
        end else if (therm_r == led_pkg::THERM_SHUT) begin
            ind_nxt.output_ok_led = 1'b0; // RULE_12
            ind_nxt.service_led = 1'b1; // RULE_12
            ind_nxt.fault_led = 1'b1; // RULE_12
            ind_nxt.fault_act = 1'b1; // RULE_12
            ind_nxt.over_temp_warn_act = 1'b1; // RULE_12
            ind_nxt.output_good_act = 1'b1; // RULE_12
        end else if (cond.boost_fail || cond.ov_latched) begin
            ind_nxt.output_ok_led = 1'b0; // RULE_12
            ind_nxt.fault_led = 1'b1; // RULE_12
            ind_nxt.fault_act = 1'b1; // RULE_12
            ind_nxt.output_good_act = 1'b1; // RULE_12
        end else if (standby) begin
            ind_nxt.output_ok_led = 1'b0; // RULE_07
            ind_nxt.output_good_act = 1'b1; // RULE_07
        end else if (cond.overload) begin
            // pulled low half of each 2 ms cycle while overloaded
            ind_nxt.output_ok_led = blink; // RULE_06
            ind_nxt.output_good_act = pg_pulse; // RULE_06
        end else if (cond.internal_fault) begin
            ind_nxt.fault_led = 1'b1; // RULE_05
            ind_nxt.fault_act = 1'b1; // RULE_05
        end else if (therm_r == led_pkg::THERM_WARN) begin
            ind_nxt.service_led = 1'b1; // RULE_02 RULE_03
            ind_nxt.over_temp_warn_act = 1'b1; // RULE_03
        end else if (cond.service_req && mode == led_pkg::MODE_I2C) begin
            ind_nxt.service_led = blink; // RULE_02 RULE_08
        end else if (cond.comm_lost && mode == led_pkg::MODE_RS485) begin
            ind_nxt.fault_led = blink; // RULE_09
        end
        // fault and warning pins have no meaning on the rs485 link
        if (!i2c_like) begin
            ind_nxt.fault_act = 1'b0; // RULE_09
            ind_nxt.over_temp_warn_act = 1'b0; // RULE_09
        end
    end

    // indications leave through flip-flops so pins never glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            ind_r <= `IND_RESET;
        end else begin
            ind_r <= ind_nxt;
        end
    end

    // front panel LEDs
    assign input_ok_led = ind_r.input_ok_led;
    assign output_ok_led = ind_r.output_ok_led;
    assign service_led = ind_r.service_led;
    assign fault_led = ind_r.fault_led;

    // open-drain pins only ever sink; the far side pulls them high
    assign fault_n_out = 1'b0; // RULE_13
    assign fault_n_oe = ind_r.fault_act; // RULE_13
    assign over_temp_warn_n_out = 1'b0; // RULE_13
    assign over_temp_warn_n_oe = ind_r.over_temp_warn_act; // RULE_13
    assign output_good_n_out = 1'b0; // RULE_13
    assign output_good_n_oe = ind_r.output_good_act; // RULE_13

    // trip request for the power stage, and state for monitoring
    assign thermal_shutdown = (therm_r == led_pkg::THERM_SHUT); // RULE_14
    assign therm_state = therm_r;

endmodule

// >>> logic/led_map.svh
// clock rate, timing figures and reset values for the rectifier status block
//
// Operation
// RULE_01: i2c mode: input LED steady when fine, flashing when out of limits.
// RULE_02: i2c: amber steady on thermal warning, flashing on service request.
// RULE_03: thermal alarm: greens on, amber on, red off, only warning pin low.
// RULE_04: input outside limits: input LED flashes, rest off, output-good low.
// RULE_05: non-fatal internal fault: greens on, red on, only fault pin low.
// RULE_06: overload: output LED blinks, input LED on, output-good pulses 1 ms.
// RULE_07: remote standby: input LED on, output LED off, output-good low.
// RULE_08: i2c service request: amber flashes, greens on, alarms released.
// RULE_09: rs485 link lost: red flashes, greens on, output-good released.
// RULE_10: input absent: all LEDs off, output-good low.
// RULE_11: normal: both greens on, amber and red off, all alarms released.
// RULE_12: thermal or boost/ov trip: output LED off, red on, alarms low; a boost/ov trip leaves the warning pin released.
// RULE_13: alarm pins are open-drain, active low, pulled up by the far side.
// RULE_14: warning pin held about ten seconds, then shutdown until recovery.
`ifndef LED_MAP_SVH
`define LED_MAP_SVH

// clock rate in kHz, 250 MHz
`define CLK_KHZ 64'd250000
// warning period before a thermal trip, in ms
`define OTW_HOLD_MS 64'd10000
// half period of a flashing LED, in ms
`define BLINK_HALF_MS 64'd500
// half period of output-good pulsing during overload, in ms
`define PG_PULSE_MS 64'd1
// reset value of every LED and alarm indication
`define IND_RESET 7'h00

`endif

// >>> logic/led_pkg.sv
// types shared by the rectifier status logic
package led_pkg;

    // protocol strap setting
    typedef enum logic [1:0] {
        MODE_ANALOG = 2'h0,
        MODE_I2C = 2'h1,
        MODE_RS485 = 2'h3
    } mode_t;

    // thermal supervision, gray along ok -> warn -> shut
    typedef enum logic [1:0] {
        THERM_OK = 2'h0,
        THERM_WARN = 2'h1,
        THERM_SHUT = 2'h3
    } therm_t;

    // raw conditions reported by the power stage and the controller
    typedef struct packed {
        logic input_present;
        logic input_in_limits;
        logic over_temp;
        logic temp_recovered;
        logic boost_fail;
        logic ov_latched;
        logic overload;
        logic internal_fault;
        logic onoff_off;
        logic i2c_off_cmd;
        logic interlock_off;
        logic rs485_off_cmd;
        logic service_req;
        logic comm_lost;
    } cond_t;

    // resolved front panel and alarm picture; *_act means pin pulled low
    typedef struct packed {
        logic input_ok_led;
        logic output_ok_led;
        logic service_led;
        logic fault_led;
        logic fault_act;
        logic over_temp_warn_act;
        logic output_good_act;
    } ind_t;

endpackage

// >>> logic/toggle_gen.sv
// free running square wave with a programmable half period
`timescale 1ns/10ps
module toggle_gen #(
    parameter logic [31:0] HALF_CYCLES = 32'h0000_0002
) (
    input wire logic clk,
    input wire logic reset,
    output logic wave
);

    logic [31:0] count_r;
    logic wave_r;

    // count up one half period, then flip
    always_ff @(posedge clk) begin
        if (reset) begin
            count_r <= 32'h0000_0000;
        end else if (count_r >= HALF_CYCLES - 32'h0000_0001) begin
            count_r <= 32'h0000_0000;
        end else begin
            count_r <= count_r + 32'h0000_0001;
        end
    end

    // phase starts low so a fresh flash begins dark after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            wave_r <= 1'b0;
        end else if (count_r >= HALF_CYCLES - 32'h0000_0001) begin
            wave_r <= ~wave_r;
        end
    end

    assign wave = wave_r;

endmodule

// >>> verif/status_properties.sv
// assertions on the rectifier status block ports
`timescale 1ns/10ps
module status_properties (
    input wire logic clk,
    input wire logic reset,
    input wire led_pkg::mode_t mode,
    input wire led_pkg::cond_t cond,
    input wire logic input_ok_led,
    input wire logic output_ok_led,
    input wire logic service_led,
    input wire logic fault_led,
    input wire logic fault_n_out,
    input wire logic fault_n_oe,
    input wire logic over_temp_warn_n_out,
    input wire logic over_temp_warn_n_oe,
    input wire logic output_good_n_out,
    input wire logic output_good_n_oe,
    input wire led_pkg::therm_t therm_state
);
    led_pkg::cond_t c_r;
    led_pkg::mode_t m_r;
    led_pkg::therm_t t_r;
    logic v_r, rs, stb, base, hi, calm;
    logic [3:0] l;
    logic [2:0] o;
    // one edge of history, since the picture trails its causes by an edge
    always_ff @(posedge clk) begin
        c_r <= cond;
        m_r <= mode;
        t_r <= therm_state;
        v_r <= !reset;
    end
    // priority ladder of the conditions, highest first
    assign l = {input_ok_led, output_ok_led, service_led, fault_led};
    assign o = {fault_n_oe, over_temp_warn_n_oe, output_good_n_oe};
    assign rs = m_r == led_pkg::MODE_RS485;
    assign stb = rs ? c_r.interlock_off | c_r.rs485_off_cmd
                    : c_r.onoff_off | c_r.i2c_off_cmd;
    assign base = v_r && c_r.input_present && c_r.input_in_limits;
    assign hi = base && t_r != led_pkg::THERM_SHUT && !c_r.boost_fail
        && !c_r.ov_latched;
    assign calm = hi && !stb && !c_r.overload && !c_r.internal_fault;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_input_absent: assert property (
        v_r && !c_r.input_present |-> l == 4'h0 && o == 3'h1)
        else $error("picture wrong with input absent");
    a_input_limits: assert property (
        v_r && c_r.input_present && !c_r.input_in_limits
        |-> l[2:0] == 3'h0 && o == 3'h1)
        else $error("picture wrong with input out of limits");
    a_thermal_trip: assert property (
        base && t_r == led_pkg::THERM_SHUT
        |-> l == 4'hb && o == {!rs, !rs, 1'b1})
        else $error("picture wrong in thermal shutdown");
    a_boost_trip: assert property (
        base && t_r != led_pkg::THERM_SHUT && (c_r.boost_fail | c_r.ov_latched)
        |-> l == 4'h9 && o == {!rs, 2'h1})
        else $error("picture wrong on boost or overvoltage trip");
    a_standby_pic: assert property (
        hi && stb |-> l[3:2] == 2'h2 && o[0])
        else $error("picture wrong in standby");
    a_overload_pic: assert property (
        hi && !stb && c_r.overload
        |-> l[3] && l[1:0] == 2'h0 && o[2:1] == 2'h0)
        else $error("picture wrong in overload");
    a_fault_pic: assert property (
        calm || !hi || stb || c_r.overload || !c_r.internal_fault
        || l == 4'hd && o == {!rs, 2'h0})
        else $error("picture wrong on internal fault");
    a_warn_pic: assert property (
        calm && t_r == led_pkg::THERM_WARN
        |-> l == 4'he && o == {1'b0, !rs, 1'b0})
        else $error("picture wrong in thermal warning");
    a_normal_pic: assert property (
        calm && t_r == led_pkg::THERM_OK && !c_r.service_req && !c_r.comm_lost
        |-> l == 4'hc && o == 3'h0)
        else $error("picture wrong in normal running");
    a_pins_low: assert property (
        {fault_n_out, over_temp_warn_n_out, output_good_n_out} == 3'h0)
        else $error("alarm pin drives high");
    c_thermal_trip: cover property (base && t_r == led_pkg::THERM_SHUT);
    c_overload: cover property (hi && !stb && c_r.overload);
    c_standby: cover property (hi && stb);
endmodule
bind rectifier_alarm_led_status status_properties chk (.clk, .reset, .mode,
    .cond, .input_ok_led, .output_ok_led, .service_led, .fault_led,
    .fault_n_out, .fault_n_oe, .over_temp_warn_n_out, .over_temp_warn_n_oe,
    .output_good_n_out, .output_good_n_oe, .therm_state);

// >>> verif/alarm_pullups.sv
// controller side of the three open-drain alarm lines
`timescale 1ns/10ps
module alarm_pullups (
    input wire logic [2:0] oe,
    input wire logic [2:0] drv,
    output logic [2:0] line
);
    // a released line floats up through the external resistor
    assign line = (oe & drv) | ~oe;
endmodule

// >>> verif/test_rectifier_alarm_led_status.sv
// self-checking bench for the rectifier status block
`timescale 1ns/10ps
module test_rectifier_alarm_led_status;
    localparam int HOLD = 20;
    logic clk = 0, reset = 1;
    led_pkg::mode_t mode = led_pkg::MODE_I2C;
    led_pkg::cond_t cond = '0;
    logic input_ok_led, output_ok_led, service_led, fault_led;
    logic fault_n_out, fault_n_oe, fault_n_in, over_temp_warn_n_out;
    logic over_temp_warn_n_oe, over_temp_warn_n_in, output_good_n_out;
    logic output_good_n_oe, output_good_n_in, thermal_shutdown;
    led_pkg::therm_t therm_state;
    logic [6:0] v;
    logic [6:0] pq[$];
    int tq[$];
    int num_errors = 0, n_checks = 0, tn = 0, tseen, n;
    logic [1:0] m;
    event pe, te;
    always #2 clk = ~clk;
    rectifier_alarm_led_status #(.OTW_HOLD_CYCLES(HOLD),
        .BLINK_HALF_CYCLES(4), .PG_PULSE_CYCLES(2)) uut (.clk, .reset,
        .mode, .cond, .input_ok_led, .output_ok_led, .service_led,
        .fault_led, .fault_n_in, .fault_n_out, .fault_n_oe,
        .over_temp_warn_n_in, .over_temp_warn_n_out, .over_temp_warn_n_oe,
        .output_good_n_in, .output_good_n_out, .output_good_n_oe,
        .thermal_shutdown, .therm_state);
    alarm_pullups far (.oe({fault_n_oe, over_temp_warn_n_oe,
        output_good_n_oe}), .drv({fault_n_out, over_temp_warn_n_out,
        output_good_n_out}), .line({fault_n_in, over_temp_warn_n_in,
        output_good_n_in}));
    // leds, then the line levels the controller sees
    assign v = {input_ok_led, output_ok_led, service_led, fault_led,
        fault_n_in, over_temp_warn_n_in, output_good_n_in};
    task automatic cmp_pic(input logic [6:0] e, input logic [6:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH picture expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_tog(input int e, input int g);
        n_checks++;
        if (g != e) begin
            num_errors++;
            $display("MISMATCH count expected %0d seen %0d", e, g);
        end
    endtask
    // the watcher takes the oldest note whenever a result is posted
    always @(pe) cmp_pic(pq.pop_front(), v);
    always @(te) cmp_tog(tq.pop_front(), tseen);
    task automatic step(input logic [1:0] md, input logic [13:0] c);
        @(negedge clk);
        mode = led_pkg::mode_t'(md);
        cond = c;
        repeat (3) @(negedge clk);
    endtask
    task automatic pic(input logic [1:0] md, input logic [13:0] c,
        input logic [3:0] el, input logic [2:0] eo);
        step(md, c);
        pq.push_back({el, ~eo});
        -> pe;
        $display("test %0d done", ++tn);
    endtask
    // counts level changes of one output over 16 edges
    task automatic tog(input logic [1:0] md, input logic [13:0] c,
        input int idx, input int e);
        logic [6:0] p;
        int k;
        step(md, c);
        p = v;
        k = 0;
        repeat (16) begin
            @(negedge clk);
            k += int'(v[idx] !== p[idx]);
            p = v;
        end
        tq.push_back(e);
        tseen = k;
        -> te;
        $display("test %0d done", ++tn);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(19372));
        repeat (8) @(negedge clk);
        reset = 0;
        pic(1, 14'h3000, 4'hc, 3'h0);
        pic(1, 14'h3040, 4'hd, 3'h4);
        pic(3, 14'h3040, 4'hd, 3'h0);
        pic(1, 14'h3200, 4'h9, 3'h5);
        pic(1, 14'h3100, 4'h9, 3'h5);
        pic(1, 14'h3020, 4'h8, 3'h1);
        pic(1, 14'h3010, 4'h8, 3'h1);
        pic(3, 14'h3008, 4'h8, 3'h1);
        pic(3, 14'h3004, 4'h8, 3'h1);
        pic(1, 14'h3008, 4'hc, 3'h0);
        tog(1, 14'h2000, 6, 4);
        tog(1, 14'h3080, 5, 4);
        tog(1, 14'h3080, 0, 8);
        tog(1, 14'h3002, 4, 4);
        tog(3, 14'h3002, 4, 0);
        tog(3, 14'h3001, 3, 4);
        tog(1, 14'h3001, 3, 0);
        // analog strap: no service flash, pin standby still honoured
        tog(0, 14'h3002, 4, 0);
        pic(0, 14'h3020, 4'h8, 3'h1);
        pic(1, 14'h3800, 4'he, 3'h2);
        for (n = 0; n < 100 && thermal_shutdown !== 1'b1; n++) @(negedge clk);
        // warn starts one edge after the change and lasts HOLD edges
        if (n == 100) begin
            num_errors++;
        end else begin
            cmp_tog(HOLD - 2, n);
            pic(1, 14'h3800, 4'hb, 3'h7);
            pic(1, 14'h3400, 4'hc, 3'h0);
        end
        // over-temperature bit kept clear so the thermal state stays idle
        repeat (4) begin
            m = 2'($urandom % 3);
            pic(m | {1'b0, m[1]}, {2'h0, 12'($urandom) & 12'h7ff},
                4'h0, 3'h1);
        end
        repeat (2) @(negedge clk);
        final_report();
    end
endmodule
